// ---- cscr_pkg.sv ----
// Constants, field layout and decode functions for the setup control register.
// Assumes one 100 MHz clock; every long interval is counted in that clock.
package cscr_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] CSCR_SETUP_ADDR = 12'h000;
	localparam logic [15:0] CSCR_SETUP_RESET = 16'h0000;
	localparam logic [15:0] CSCR_SETUP_WMASK = 16'hDFFF;

	// ==========================================================
	// Field positions
	localparam int MODE_LSB = 0;
	localparam int SLEEP_LSB = 2;
	localparam int STAGES_LSB = 4;
	localparam int DECIM_LSB = 8;
	localparam int SOFT_RESET_POS = 10;
	localparam int IRQ_POL_POS = 11;
	localparam int EXC_DIS_POS = 12;
	localparam int BIAS_LSB = 14;

	// ==========================================================
	// Encodings
	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_LOW = 2'h2;
	localparam logic [3:0] STAGE_MAX = 4'hB;

	// ==========================================================
	// Timing
	localparam longint unsigned CLK_HZ = 64'd100000000;
	localparam longint unsigned FULL_PERIOD_MS = 64'd36;
	localparam longint unsigned SLEEP_STEP_MS = 64'd200;
	localparam longint unsigned FULL_PERIOD_CYC = FULL_PERIOD_MS * CLK_HZ / 64'd1000;
	localparam longint unsigned SLEEP_STEP_CYC = SLEEP_STEP_MS * CLK_HZ / 64'd1000;

	// Last stage index of a sequence, clamped at the largest legal value
	function automatic logic [3:0] cscr_last_stage(input logic [3:0] n);
		cscr_last_stage = (n > STAGE_MAX) ? STAGE_MAX : n;
	endfunction

	// Oversampling ratio from the decimation field
	function automatic logic [8:0] cscr_decim(input logic [1:0] f);
		case (f)
			2'h0: cscr_decim = 9'h100;
			2'h1: cscr_decim = 9'h080;
			default: cscr_decim = 9'h040;
		endcase
	endfunction

	// Bias boost in percent from the bias field
	function automatic logic [5:0] cscr_bias(input logic [1:0] f);
		case (f)
			2'h0: cscr_bias = 6'h00;
			2'h1: cscr_bias = 6'h14;
			2'h2: cscr_bias = 6'h23;
			default: cscr_bias = 6'h32;
		endcase
	endfunction

endpackage

// ---- cscr_timer.sv ----
// Down-counting interval timer with a one-cycle expiry pulse.
// Assumes load is a single-cycle pulse; a new load restarts the count.
`timescale 1ns/1ps
module cscr_timer #(
	parameter int W = 32
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic load_i,
	input wire logic [W-1:0] load_val_i,
	output logic expire_o
);
	// ==========================================================
	// Counter
	logic [W-1:0] cnt_q, cnt_d;
	logic exp_q, exp_d;

	// Next count and expiry, expiry lands load_val cycles after load
	always_comb begin
		cnt_d = cnt_q;
		exp_d = 1'b0;
		if (load_i) begin
			cnt_d = load_val_i;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
			exp_d = (cnt_q == W'(1));
		end
	end

	// Register the count
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign expire_o = exp_q;
endmodule // cscr_timer

// ---- cscr_top.sv ----
// Setup control register and conversion sequencer of the converter.
// Assumes the serial interface delivers one-cycle register read/write strobes.
`timescale 1ns/1ps
module cscr_top import cscr_pkg::*; #(
	parameter int unsigned FULL_CYC = 32'(FULL_PERIOD_CYC),
	parameter int unsigned SLEEP_CYC = 32'(SLEEP_STEP_CYC)
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	input wire logic conv_done_i,
	input wire logic irq_event_i,
	output logic stage_start_o,
	output logic [3:0] stage_idx_o,
	output logic seq_done_o,
	output logic [8:0] decim_ratio_o,
	output logic [5:0] bias_boost_o,
	output logic excitation_en_o,
	output logic irq_o
);
	// ==========================================================
	// Register file
	logic [15:0] setup_q, setup_d;
	logic [15:0] rdata_q, rdata_d;
	logic wr_hit, soft_reset;
	logic [1:0] mode;
	logic active;

	assign wr_hit = reg_wr_i && (reg_addr_i == CSCR_SETUP_ADDR);
	assign soft_reset = wr_hit && reg_wdata_i[SOFT_RESET_POS];
	assign mode = setup_q[MODE_LSB +: 2];
	assign active = (mode == MODE_FULL) || (mode == MODE_LOW);

	// Register write and read-back
	always_comb begin
		setup_d = setup_q;
		rdata_d = rdata_q;
		if (soft_reset) begin
			setup_d = CSCR_SETUP_RESET;
		end else if (wr_hit) begin
			setup_d = reg_wdata_i & CSCR_SETUP_WMASK;
		end
		if (reg_rd_i) begin
			rdata_d = (reg_addr_i == CSCR_SETUP_ADDR) ? setup_q : 16'h0000;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			setup_q <= CSCR_SETUP_RESET;
			rdata_q <= 16'h0000;
		end else begin
			setup_q <= setup_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// Static controls
	logic [8:0] decim_q, decim_d;
	logic [5:0] bias_q, bias_d;
	logic exc_q, exc_d, irq_q, irq_d;

	// Decode fields into the converter controls and interrupt pin
	always_comb begin
		decim_d = cscr_decim(setup_q[DECIM_LSB +: 2]);
		bias_d = cscr_bias(setup_q[BIAS_LSB +: 2]);
		exc_d = !setup_q[EXC_DIS_POS];
		irq_d = setup_q[IRQ_POL_POS] ? irq_event_i : !irq_event_i;
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			decim_q <= 9'h100;
			bias_q <= 6'h00;
			exc_q <= 1'b1;
			irq_q <= 1'b1;
		end else begin
			decim_q <= decim_d;
			bias_q <= bias_d;
			exc_q <= exc_d;
			irq_q <= irq_d;
		end
	end

	// ==========================================================
	// Sequencer
	typedef enum logic [1:0] {
		SQ_OFF = 2'b00,
		SQ_WAIT = 2'b01,
		SQ_STAGE = 2'b11,
		SQ_CONV = 2'b10
	} cscr_state_t;

	cscr_state_t state_q, state_d;
	logic [3:0] stage_q, stage_d, last_stage;
	logic start_q, start_d, done_q, done_d;
	logic tmr_load, tmr_expire;
	logic [31:0] wait_cyc;

	assign last_stage = cscr_last_stage(setup_q[STAGES_LSB +: 4]);
	// Interval between sequences for the current mode
	assign wait_cyc = (mode == MODE_LOW) ?
		32'(SLEEP_CYC * (32'(setup_q[SLEEP_LSB +: 2]) + 32'd1)) : 32'(FULL_CYC);
	assign tmr_load = (state_d == SQ_WAIT) && (state_q != SQ_WAIT);

	// Next state: wait, then walk stages 0..N, then wait again
	always_comb begin
		state_d = state_q;
		stage_d = stage_q;
		start_d = 1'b0;
		done_d = 1'b0;
		case (state_q)
			SQ_OFF: begin
				stage_d = 4'h0;
				if (active) begin
					state_d = SQ_WAIT;
				end
			end
			SQ_WAIT: begin
				if (!active) begin
					state_d = SQ_OFF;
				end else if (tmr_expire) begin
					state_d = SQ_STAGE;
				end
			end
			SQ_STAGE: begin
				if (!active) begin
					state_d = SQ_OFF;
				end else begin
					start_d = 1'b1;
					state_d = SQ_CONV;
				end
			end
			SQ_CONV: begin
				if (!active) begin
					state_d = SQ_OFF;
					stage_d = 4'h0;
				end else if (conv_done_i) begin
					if (stage_q >= last_stage) begin
						stage_d = 4'h0;
						done_d = 1'b1;
						state_d = SQ_WAIT;
					end else begin
						stage_d = stage_q + 4'h1;
						state_d = SQ_STAGE;
					end
				end
			end
			default: begin
				state_d = SQ_OFF;
			end
		endcase
		// Soft reset drops any stage start or end pulse about to be issued
		if (soft_reset) begin
			state_d = SQ_OFF;
			stage_d = 4'h0;
			start_d = 1'b0;
			done_d = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= SQ_OFF;
			stage_q <= 4'h0;
			start_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			stage_q <= stage_d;
			start_q <= start_d;
			done_q <= done_d;
		end
	end

	// Interval timer between sequences
	cscr_timer #(.W(32)) u_timer (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.load_i(tmr_load),
		.load_val_i(wait_cyc),
		.expire_o(tmr_expire)
	);

	// ==========================================================
	// Outputs
	assign reg_rdata_o = rdata_q;
	assign stage_start_o = start_q;
	assign stage_idx_o = stage_q;
	assign seq_done_o = done_q;
	assign decim_ratio_o = decim_q;
	assign bias_boost_o = bias_q;
	assign excitation_en_o = exc_q;
	assign irq_o = irq_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	full_interval_a: assert property (
		tmr_load && mode == MODE_FULL |-> wait_cyc == FULL_CYC)
		else $error("full power interval wrong");
	shutdown_quiet_a: assert property (
		!active ##1 !active |-> !stage_start_o)
		else $error("stage started in shutdown");
	lowpower_wake_a: assert property (
		state_q == SQ_WAIT && tmr_expire && active && !soft_reset ##1
		active && !soft_reset |=> stage_start_o)
		else $error("wake did not start a stage");
	sleep_interval_a: assert property (
		tmr_load && mode == MODE_LOW |-> wait_cyc == (
		(setup_q[SLEEP_LSB +: 2] == 2'h0) ? SLEEP_CYC :
		(setup_q[SLEEP_LSB +: 2] == 2'h1) ? 32'(2 * SLEEP_CYC) :
		(setup_q[SLEEP_LSB +: 2] == 2'h2) ? 32'(3 * SLEEP_CYC) : 32'(4 * SLEEP_CYC)))
		else $error("sleep interval wrong");
	stage_limit_a: assert property (
		stage_start_o |-> stage_idx_o <= $past(last_stage, 2))
		else $error("stage index beyond sequence length");
	decim_map_a: assert property (
		##1 decim_ratio_o == (($past(setup_q[DECIM_LSB +: 2]) == 2'h0) ? 9'h100 :
		($past(setup_q[DECIM_LSB +: 2]) == 2'h1) ? 9'h080 : 9'h040))
		else $error("decimation ratio wrong");
	soft_reset_a: assert property (
		soft_reset |=> setup_q == CSCR_SETUP_RESET && !setup_q[SOFT_RESET_POS])
		else $error("soft reset did not restore defaults");
	irq_polarity_a: assert property (
		##1 irq_o == ($past(irq_event_i) ~^ $past(setup_q[IRQ_POL_POS])))
		else $error("interrupt polarity wrong");
	excitation_gate_a: assert property (
		##1 excitation_en_o == !$past(setup_q[EXC_DIS_POS]))
		else $error("excitation gate wrong");
	bias_map_a: assert property (
		##1 bias_boost_o == (($past(setup_q[BIAS_LSB +: 2]) == 2'h0) ? 6'h00 :
		($past(setup_q[BIAS_LSB +: 2]) == 2'h1) ? 6'h14 :
		($past(setup_q[BIAS_LSB +: 2]) == 2'h2) ? 6'h23 : 6'h32))
		else $error("bias boost wrong");
endmodule // cscr_top

// ---- cscr_conv_model.sv ----
// Behavioural converter on the far side of the sequencer.
// Assumes stage_start_i is a one-cycle pulse; answers DLY cycles later.
`timescale 1ns/1ps
module cscr_conv_model #(
	parameter int DLY = 3
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic stage_start_i,
	output logic conv_done_o
);
	// ==========================================================
	// Stage timer
	int cnt_q;
	// Count down from each start and pulse done for one cycle at the end
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 0;
			conv_done_o <= 1'b0;
		end else begin
			conv_done_o <= (cnt_q == 1);
			cnt_q <= stage_start_i ? DLY : ((cnt_q > 0) ? cnt_q - 1 : 0);
		end
	end
endmodule // cscr_conv_model

// ---- cdc_setup_control_register_tb.sv ----
// Self-checking bench for the setup control register and sequencer.
// Assumes shortened intervals: FULL_CYC 20 and SLEEP_CYC 10 cycles.
`timescale 1ns/1ps
module cdc_setup_control_register_tb;
	// ==========================================================
	// Signals
	localparam int FC = 20;
	localparam int SC = 10;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [15:0] wd = 16'h0000;
	logic irq_ev = 1'b0;
	logic cdone;
	logic [15:0] reg_rdata_o;
	logic stage_start_o;
	logic [3:0] stage_idx_o;
	logic seq_done_o;
	logic [8:0] decim_ratio_o;
	logic [5:0] bias_boost_o;
	logic excitation_en_o;
	logic irq_o;
	int fail_count = 0;
	int checks = 0;
	int st_cnt = 0;
	int k;
	logic [8:0] dx [4] = '{9'h100, 9'h080, 9'h040, 9'h040};
	logic [5:0] bx [4] = '{6'h00, 6'h14, 6'h23, 6'h32};

	// Clock and stage-start counter
	always #5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (stage_start_o === 1'b1) st_cnt <= st_cnt + 1;
	end

	cscr_top #(.FULL_CYC(FC), .SLEEP_CYC(SC)) DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_rdata_o(reg_rdata_o), .conv_done_i(cdone), .irq_event_i(irq_ev),
		.stage_start_o(stage_start_o), .stage_idx_o(stage_idx_o), .seq_done_o(seq_done_o),
		.decim_ratio_o(decim_ratio_o), .bias_boost_o(bias_boost_o),
		.excitation_en_o(excitation_en_o), .irq_o(irq_o));
	cscr_conv_model #(.DLY(3)) conv (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.stage_start_i(stage_start_o), .conv_done_o(cdone));

	// ==========================================================
	// Tasks
	task automatic end_sim();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge mclk_i);
			#1;
		end
	endtask
	task automatic wrt(input logic [11:0] a, input logic [15:0] d);
		tick(1);
		wr = 1'b1;
		addr = a;
		wd = d;
		tick(1);
		wr = 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [15:0] exp);
		tick(1);
		rd = 1'b1;
		addr = a;
		tick(1);
		rd = 1'b0;
		tick(1);
		chk(reg_rdata_o, exp);
	endtask
	// Bounded wait for a stage start (w=0) or a sequence end (w=1)
	task automatic wev(input bit w, output int n);
		n = 0;
		do begin
			tick(1);
			n++;
		end while ((w ? seq_done_o : stage_start_o) !== 1'b1 && n < 400);
		if (n >= 400) begin
			fail_count++;
			$display("ERROR t=%0t wait timed out", $time);
			end_sim();
		end
	endtask
	// One whole sequence; gap from the previous end must fall in lo..hi
	task automatic seq(input int st, input int lo, input int hi);
		int n;
		wev(1'b0, n);
		chk({15'h0, n >= lo && n <= hi}, 16'h0001);
		chk({12'h0, stage_idx_o}, 16'h0000);
		for (int i = 1; i < st; i++) begin
			wev(1'b0, n);
			chk({12'h0, stage_idx_o}, 16'(i));
		end
		wev(1'b1, n);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		tick(12);
		rst_b_i = 1'b1;
		rdc(12'h000, 16'h0000);
		chk({15'h0, excitation_en_o}, 16'h0001);
		// Low power, longest wait, stage field above the limit
		wrt(12'h000, 16'hFBFE);
		rdc(12'h000, 16'hDBFE);
		chk({15'h0, excitation_en_o}, 16'h0000);
		irq_ev = 1'b1;
		tick(2);
		chk({15'h0, irq_o}, 16'h0001);
		seq(12, 0, 400);
		seq(12, SC * 4 + 1, SC * 4 + 5);
		// Decimation and bias tables under both shutdown codes
		for (int f = 0; f < 4; f++) begin
			wrt(12'h000, 16'(f << 14 | f << 8 | (f % 2 ? 3 : 1)));
			tick(2);
			k = st_cnt;
			tick(60);
			chk(16'(st_cnt - k), 16'h0000);
			chk({7'h0, decim_ratio_o}, {7'h0, dx[f]});
			chk({10'h0, bias_boost_o}, {10'h0, bx[f]});
		end
		chk({15'h0, irq_o}, 16'h0000);
		// Active-low pin must rise again once the request goes away
		irq_ev = 1'b0;
		tick(2);
		chk({15'h0, irq_o}, 16'h0001);
		// Low power with the three shorter wait codes, one stage each
		for (int s = 0; s < 3; s++) begin
			wrt(12'h000, 16'(s << 2 | 2));
			seq(1, 0, 400);
			seq(1, SC * (s + 1) + 1, SC * (s + 1) + 5);
		end
		// Full power, three stages
		wrt(12'h000, 16'h0020);
		seq(3, 0, 400);
		seq(3, FC + 1, FC + 5);
		// Unmapped address leaves the register alone
		wrt(12'h001, 16'hFFFF);
		rdc(12'h001, 16'h0000);
		rdc(12'h000, 16'h0020);
		// Soft reset discards the rest of the write and self-clears
		wrt(12'h000, 16'h0C12);
		rdc(12'h000, 16'h0000);
		tick(3);
		rdc(12'h000, 16'h0000);
		chk({7'h0, decim_ratio_o}, 16'h0100);
		end_sim();
	end
endmodule // cdc_setup_control_register_tb
